// ==== hw/ipa_pkg.sv ====
// Constants and types of the interrupt priority and acceptance block
// Function
// - Pick the pending request with the highest programmed priority level.
// - Equal levels or same-module sources resolve by fixed default order.
// - Ignore the winner when its level is at or below the CPU mask.
// - Winner above the CPU mask is accepted and requested toward the CPU.
// - Acceptance drives the active-low indicator pin low.
// - Controller presents accepted level; CPU loads it into its mask bits.
// - Level-sensed or on-chip acceptance releases the indicator pin high.
// - Edge-sensed acceptance releases the indicator when the CPU takes it.
// - A newly accepted higher-level request keeps the indicator low.
// - An edge-sensed line holds at most one pending request.
// - A level-sensed request pends only while its line stays asserted.
// - On-chip requests are levels held until the module clears them.
// - Selection and mask compare: 2 states on-chip, 3 states external.
// - Switching a low pin to interrupt input under edge sense raises a request.
// - Priority fields are four bits, zero lowest and fifteen highest.
// - Sense select bit: zero for low level, one for falling edge.
package ipa_pkg;
	localparam int NUM_EXT = 8;
	localparam int NUM_PER = 8;
	localparam int NUM_SRC = NUM_EXT + NUM_PER;
	localparam int LVL_W = 4;
	localparam int SRC_W = 4;
	localparam int NUM_PRIO_REG = 4;
	localparam logic [7:0] OFS_PRIO0 = 8'h00;
	localparam logic [7:0] OFS_PRIO1 = 8'h04;
	localparam logic [7:0] OFS_PRIO2 = 8'h08;
	localparam logic [7:0] OFS_PRIO3 = 8'h0C;
	localparam logic [7:0] OFS_SENSE = 8'h10;
	localparam logic [7:0] OFS_PINFN = 8'h14;
	localparam logic [7:0] OFS_STATUS = 8'h18;
	localparam int ST_LVL_POS = 16;
	localparam int ST_SRC_POS = 20;
	localparam int ST_REQ_POS = 24;
	localparam int ST_IND_POS = 25;
	localparam logic [15:0] RST_PRIO = 16'h0000;
	localparam logic [7:0] RST_SENSE = 8'h00;
	localparam logic [7:0] RST_PINFN = 8'h00;
	localparam logic [7:0] RST_LINE = 8'hFF;
	localparam int STATES_ONCHIP = 2;
	localparam int STATES_EXT = 3;

	typedef struct packed {
		logic [NUM_SRC*LVL_W-1:0] prio;
		logic [NUM_EXT-1:0] sense;
		logic [NUM_EXT-1:0] pinfn;
		logic [NUM_EXT-1:0] line_prev;
		logic [NUM_EXT-1:0] edge_lat;
		logic [NUM_EXT-1:0] lvl_pend;
		logic sel_vld;
		logic [LVL_W-1:0] sel_lvl;
		logic [SRC_W-1:0] sel_src;
		logic req;
		logic [LVL_W-1:0] lvl;
		logic [SRC_W-1:0] src;
		logic ind_low;
		logic ack_vld;
		logic [LVL_W-1:0] ack_lvl;
		logic [SRC_W-1:0] ack_src;
		logic [31:0] prdata;
		logic slverr;
	} ipa_state_s;
endpackage

// ==== hw/ipa_prio_sel.sv ====
// Combinational priority selector over all pending sources
`timescale 1ns/1ns
module ipa_prio_sel import ipa_pkg::*; #(
	parameter int N = NUM_SRC
) (
	input wire logic [N-1:0] req,
	input wire logic [N*LVL_W-1:0] lvl,
	output logic vld,
	output logic [LVL_W-1:0] win_lvl,
	output logic [SRC_W-1:0] win_idx
);
	// ****************************************
	// Selection
	// ****************************************
	// Scan from the lowest default priority up; ">=" lets the earlier index win ties
	always_comb begin
		vld = 1'b0;
		win_lvl = '0;
		win_idx = '0;
		for (int i = N - 1; i >= 0; i--) begin
			if (req[i] && (!vld || lvl[i*LVL_W +: LVL_W] >= win_lvl)) begin
				vld = 1'b1;
				win_lvl = lvl[i*LVL_W +: LVL_W];
				win_idx = SRC_W'(i);
			end
		end
	end
endmodule

// ==== hw/ipa_top.sv ====
// Interrupt priority and acceptance controller with APB register slave
//
// Local design decisions: the register addresses and register access over APB.
`timescale 1ns/1ns
module ipa_top import ipa_pkg::*; (
	input wire logic CLK_SYS,
	input wire logic RSTN,
	input wire logic PSEL,
	input wire logic PENABLE,
	input wire logic PWRITE,
	input wire logic [7:0] PADDR,
	input wire logic [31:0] PWDATA,
	output logic [31:0] PRDATA,
	output logic PREADY,
	output logic PSLVERR,
	input wire logic [NUM_EXT-1:0] IRQ_LINE_N,
	input wire logic [NUM_PER-1:0] PER_REQ,
	input wire logic [LVL_W-1:0] MASK_LEVEL,
	input wire logic CPU_ACK,
	output logic IRQ_REQ,
	output logic [LVL_W-1:0] IRQ_LEVEL,
	output logic [SRC_W-1:0] IRQ_SRC,
	output logic ACC_IND_N
);
	// ****************************************
	// State
	// ****************************************
	ipa_state_s st_reg;
	ipa_state_s st_next;
	logic [NUM_EXT-1:0] line_gated;
	logic [NUM_EXT-1:0] line_fall;
	logic [NUM_EXT-1:0] ext_pend;
	logic [NUM_SRC-1:0] all_pend;
	logic win_vld;
	logic [LVL_W-1:0] win_lvl;
	logic [SRC_W-1:0] win_idx;
	logic wr_en;
	logic rd_setup;
	logic ack_take;

	function automatic logic addr_known(input logic [7:0] a);
		addr_known = (a == OFS_PRIO0) || (a == OFS_PRIO1) || (a == OFS_PRIO2) || (a == OFS_PRIO3)
			|| (a == OFS_SENSE) || (a == OFS_PINFN) || (a == OFS_STATUS);
	endfunction

	// ****************************************
	// Line detection
	// ****************************************
	// General-input pins look idle, so a low pin switched in reads as a falling edge
	assign line_gated = IRQ_LINE_N | ~st_reg.pinfn;
	assign line_fall = st_reg.line_prev & ~line_gated;
	assign ext_pend = (st_reg.sense & st_reg.edge_lat) | (~st_reg.sense & st_reg.lvl_pend);
	assign all_pend = {PER_REQ, ext_pend};
	assign ack_take = CPU_ACK && st_reg.req;

	ipa_prio_sel #(
		.N(NUM_SRC)
	) u_sel (
		.req(all_pend),
		.lvl(st_reg.prio),
		.vld(win_vld),
		.win_lvl(win_lvl),
		.win_idx(win_idx)
	);

	// ****************************************
	// APB decode
	// ****************************************
	// Zero wait states; read data is captured in the setup phase
	assign wr_en = PSEL && PENABLE && PWRITE && addr_known(PADDR);
	assign rd_setup = PSEL && !PENABLE;
	assign PREADY = 1'b1;
	assign PSLVERR = PSEL && PENABLE && st_reg.slverr;
	assign PRDATA = st_reg.prdata;
	assign IRQ_REQ = st_reg.req;
	assign IRQ_LEVEL = st_reg.lvl;
	assign IRQ_SRC = st_reg.src;
	assign ACC_IND_N = ~st_reg.ind_low;

	// ****************************************
	// Next state
	// ****************************************
	always_comb begin
		logic match;
		match = 1'b0;
		st_next = st_reg;
		st_next.line_prev = line_gated;
		st_next.lvl_pend = ~line_gated;
		for (int i = 0; i < NUM_EXT; i++) begin
			// One bit per line: extra edges merge; a fresh edge beats the acknowledge clear
			if (line_fall[i] && st_reg.sense[i]) begin
				st_next.edge_lat[i] = 1'b1;
			end else if (!st_reg.sense[i] || (ack_take && st_reg.src == SRC_W'(i))) begin
				st_next.edge_lat[i] = 1'b0;
			end
		end
		st_next.sel_vld = win_vld;
		st_next.sel_lvl = win_lvl;
		st_next.sel_src = win_idx;
		st_next.req = st_reg.sel_vld && (st_reg.sel_lvl > MASK_LEVEL);
		st_next.lvl = st_reg.sel_lvl;
		st_next.src = st_reg.sel_src;
		if (ack_take) begin
			st_next.ack_vld = 1'b1;
			st_next.ack_lvl = st_reg.lvl;
			st_next.ack_src = st_reg.src;
		end else if (!st_reg.req) begin
			st_next.ack_vld = 1'b0;
		end
		// Taken request releases the pin; a different or higher winner pulls it low again
		match = st_next.ack_vld && (st_next.src == st_next.ack_src) && (st_next.lvl <= st_next.ack_lvl);
		st_next.ind_low = st_next.req && !match;
		if (wr_en) begin
			unique case (PADDR)
				OFS_PRIO0: st_next.prio[15:0] = PWDATA[15:0];
				OFS_PRIO1: st_next.prio[31:16] = PWDATA[15:0];
				OFS_PRIO2: st_next.prio[47:32] = PWDATA[15:0];
				OFS_PRIO3: st_next.prio[63:48] = PWDATA[15:0];
				OFS_SENSE: st_next.sense = PWDATA[NUM_EXT-1:0];
				OFS_PINFN: st_next.pinfn = PWDATA[NUM_EXT-1:0];
				default: st_next.prio = st_reg.prio;
			endcase
		end
		if (rd_setup) begin
			st_next.prdata = '0;
			st_next.slverr = !addr_known(PADDR);
			unique case (PADDR)
				OFS_PRIO0: st_next.prdata[15:0] = st_reg.prio[15:0];
				OFS_PRIO1: st_next.prdata[15:0] = st_reg.prio[31:16];
				OFS_PRIO2: st_next.prdata[15:0] = st_reg.prio[47:32];
				OFS_PRIO3: st_next.prdata[15:0] = st_reg.prio[63:48];
				OFS_SENSE: st_next.prdata[NUM_EXT-1:0] = st_reg.sense;
				OFS_PINFN: st_next.prdata[NUM_EXT-1:0] = st_reg.pinfn;
				OFS_STATUS: begin
					st_next.prdata[NUM_SRC-1:0] = all_pend;
					st_next.prdata[ST_LVL_POS +: LVL_W] = st_reg.lvl;
					st_next.prdata[ST_SRC_POS +: SRC_W] = st_reg.src;
					st_next.prdata[ST_REQ_POS] = st_reg.req;
					st_next.prdata[ST_IND_POS] = st_reg.ind_low;
				end
				default: st_next.prdata = '0;
			endcase
		end
	end

	// ****************************************
	// Registers
	// ****************************************
	always_ff @(posedge CLK_SYS) begin
		if (!RSTN) begin
			st_reg <= '0;
			st_reg.prio <= {NUM_PRIO_REG{RST_PRIO}};
			st_reg.sense <= RST_SENSE;
			st_reg.pinfn <= RST_PINFN;
			st_reg.line_prev <= RST_LINE;
		end else begin
			st_reg <= st_next;
		end
	end

	// ****************************************
	// Checks
	// ****************************************
	default clocking cb @(posedge CLK_SYS); endclocking
	default disable iff (!RSTN);

	sequence s_taken;
		CPU_ACK && IRQ_REQ;
	endsequence
	sequence s_same_again;
		IRQ_SRC == $past(IRQ_SRC) && IRQ_LEVEL <= $past(IRQ_LEVEL);
	endsequence

	ind_needs_req_a: assert property (!ACC_IND_N |-> IRQ_REQ)
		else $error("indicator low without accepted request");
	idle_high_a: assert property (!IRQ_REQ |-> ACC_IND_N)
		else $error("indicator low while idle");
	mask_gate_a: assert property ($rose(IRQ_REQ) |-> $past(st_reg.sel_lvl) > $past(MASK_LEVEL))
		else $error("request raised at or below mask");
	per_sel_a: assert property ((|PER_REQ) |=> st_reg.sel_vld ##1 (IRQ_LEVEL == $past(st_reg.sel_lvl)
		&& IRQ_REQ == ($past(st_reg.sel_lvl) > $past(MASK_LEVEL))))
		else $error("on-chip request not selected within two states");
	ext_sel_a: assert property ((|(line_fall & st_reg.sense)) |=> (|st_reg.edge_lat) ##1 st_reg.sel_vld)
		else $error("edge request not selected within three states");
	edge_once_a: assert property ((st_reg.edge_lat & ~$past(st_reg.edge_lat) & ~$past(line_fall)) == '0)
		else $error("edge latch set without an edge");
	lvl_drop_a: assert property (1'b1 |=> (st_reg.lvl_pend & $past(line_gated)) == '0)
		else $error("level request pending after line released");
	ack_release_a: assert property (s_taken ##1 s_same_again |-> ACC_IND_N)
		else $error("indicator not released after acceptance");
	higher_keep_a: assert property (IRQ_REQ && st_reg.ack_vld && IRQ_LEVEL > st_reg.ack_lvl |-> !ACC_IND_N)
		else $error("indicator released despite higher request");
	pin_switch_a: assert property ((st_reg.sense & st_reg.pinfn & ~IRQ_LINE_N & st_reg.line_prev) != '0
		|=> (st_reg.edge_lat & $past(st_reg.sense & st_reg.pinfn & ~IRQ_LINE_N & st_reg.line_prev)) != '0)
		else $error("switched low pin raised no request");
	win_src_a: assert property (st_reg.sel_vld |-> ($past(all_pend) & (16'h0001 << st_reg.sel_src)) != 16'h0000)
		else $error("selected a source that was not pending");
	// Presented level lags the priority fields by two states
	lvl_present_a: assert property (IRQ_REQ && st_reg.prio == $past(st_reg.prio)
		&& st_reg.prio == $past(st_reg.prio, 2)
		|-> IRQ_LEVEL == st_reg.prio[IRQ_SRC*LVL_W +: LVL_W])
		else $error("presented level differs from source priority");
endmodule

// ==== test/ipa_cpu_model.sv ====
// CPU model answering accepted requests with exception entry
`timescale 1ns/1ns
module ipa_cpu_model import ipa_pkg::*; (
	input wire logic clk,
	input wire logic rstn,
	input wire logic irq_req,
	input wire logic [LVL_W-1:0] irq_level,
	input wire logic [SRC_W-1:0] irq_src,
	input wire logic ack_en,
	input wire logic [3:0] delay,
	input wire logic set_mask,
	input wire logic [LVL_W-1:0] mask_in,
	output logic cpu_ack,
	output logic [LVL_W-1:0] mask_level,
	output int acks
);
	int wait_cnt;
	int busy;
	logic [31:0] pc;
	logic [31:0] stack[$];
	always @(posedge clk) begin
		cpu_ack <= 1'b0;
		if (!rstn) begin
			mask_level <= 4'h0;
			wait_cnt <= 0;
			busy <= 0;
			acks <= 0;
			pc <= 32'h00000100;
		end else if (set_mask) begin
			mask_level <= mask_in;
		end else if (busy > 0) begin
			busy <= busy - 1;
		end else if (ack_en && irq_req) begin
			if (wait_cnt < delay) begin
				wait_cnt <= wait_cnt + 1;
			end else begin
				cpu_ack <= 1'b1;
				stack.push_back({28'h0000000, mask_level});
				stack.push_back(pc);
				mask_level <= irq_level;
				pc <= 32'h00000200 + 32'(irq_src) * 4;
				busy <= 8;
				wait_cnt <= 0;
				acks <= acks + 1;
			end
		end else begin
			wait_cnt <= 0;
		end
	end
endmodule

// ==== test/test_interrupt_priority_acceptance.sv ====
// Self-checking bench of the interrupt priority and acceptance block
`timescale 1ns/1ns
`define CHK(g, e) begin comparisons++; if ((g) !== (e)) begin fails++; $display("mismatch at %0t: got %h exp %h", $time, g, e); end end
module test_interrupt_priority_acceptance import ipa_pkg::*;;
	logic clk_sys = 1'b0;
	logic rstn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0, ack_en = 1'b0, set_mask = 1'b0;
	logic [7:0] paddr = 8'h00;
	logic [31:0] pwdata = 32'h00000000, prdata, rd;
	logic [31:0] seed = 32'h00000057;
	logic pready, pslverr, cpu_ack, irq_req, acc_ind_n, err;
	logic [NUM_EXT-1:0] line_n = 8'hFF;
	logic [NUM_PER-1:0] per_req = 8'h00;
	logic [LVL_W-1:0] mask_level, irq_level, mask_in = 4'h0;
	logic [SRC_W-1:0] irq_src;
	logic [3:0] delay = 4'h6;
	int fails = 0, comparisons = 0, acks, lv[NUM_SRC];
	ipa_top ipa_top_i (.CLK_SYS(clk_sys), .RSTN(rstn), .PSEL(psel), .PENABLE(penable), .PWRITE(pwrite),
		.PADDR(paddr), .PWDATA(pwdata), .PRDATA(prdata), .PREADY(pready), .PSLVERR(pslverr),
		.IRQ_LINE_N(line_n), .PER_REQ(per_req), .MASK_LEVEL(mask_level), .CPU_ACK(cpu_ack),
		.IRQ_REQ(irq_req), .IRQ_LEVEL(irq_level), .IRQ_SRC(irq_src), .ACC_IND_N(acc_ind_n));
	ipa_cpu_model ipa_cpu_model_i (.clk(clk_sys), .rstn(rstn), .irq_req(irq_req), .irq_level(irq_level),
		.irq_src(irq_src), .ack_en(ack_en), .delay(delay), .set_mask(set_mask), .mask_in(mask_in),
		.cpu_ack(cpu_ack), .mask_level(mask_level), .acks(acks));
	initial begin
		forever #10 clk_sys = ~clk_sys;
	end
	function automatic logic [31:0] xs();
		seed ^= seed << 13;
		seed ^= seed >> 17;
		seed ^= seed << 5;
		return seed;
	endfunction
	// Entered and left just after a rising edge
	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge clk_sys);
		penable <= 1'b1;
		@(posedge clk_sys);
		while (pready !== 1'b1) @(posedge clk_sys);
		rd = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		@(posedge clk_sys);
	endtask
	task automatic wprio();
		logic [15:0] v;
		for (int k = 0; k < NUM_PRIO_REG; k++) begin
			for (int j = 0; j < 4; j++) v[j*4+:4] = 4'(lv[k*4+j]);
			apb(1'b1, OFS_PRIO0 + 8'(4 * k), {16'h0000, v});
		end
	endtask
	task automatic setmask(input logic [3:0] m);
		set_mask <= 1'b1;
		mask_in <= m;
		@(posedge clk_sys);
		set_mask <= 1'b0;
	endtask
	task automatic check(input logic [NUM_SRC-1:0] act, input int msk);
		int b;
		b = -1;
		for (int i = 0; i < NUM_SRC; i++) if (act[i] && (b < 0 || lv[i] > lv[b])) b = i;
		if (b >= 0 && lv[b] > msk) begin
			`CHK(irq_req, 1'b1)
			`CHK(irq_level, 4'(lv[b]))
			`CHK(irq_src, 4'(b))
			`CHK(acc_ind_n, 1'b0)
		end else begin
			`CHK(irq_req, 1'b0)
		end
	endtask
	task automatic final_report();
		$display("comparisons %0d fails %0d", comparisons, fails);
		if (fails == 0 && comparisons > 0) begin
			$display("verification passed");
		end else begin
			$display("verification failed");
		end
		$finish;
	endtask
	initial begin
		#(20 * 20000);
		fails++;
		$display("mismatch at %0t: watchdog", $time);
		final_report();
	end
	initial begin
		repeat (5) @(posedge clk_sys);
		rstn <= 1'b1;
		@(posedge clk_sys);
		#1 `CHK(acc_ind_n, 1'b1)
		@(posedge clk_sys);
		apb(1'b0, OFS_STATUS, 32'h00000000);
		`CHK(rd, 32'h00000000)
		apb(1'b0, 8'h1C, 32'h00000000);
		`CHK(err, 1'b1)
		// Lines still idle high when made interrupt inputs
		apb(1'b1, OFS_PINFN, 32'h000000FF);
		// ****************************************
		// Random arbitration over level sources
		// ****************************************
		for (int n = 0; n < 40; n++) begin
			for (int i = 0; i < NUM_SRC; i++) lv[i] = int'(xs() & 32'h0000000F);
			wprio();
			apb(1'b0, OFS_PRIO0 + 8'(4 * (n % 4)), 32'h00000000);
			`CHK(rd, {16'h0000, 4'(lv[4*(n%4)+3]), 4'(lv[4*(n%4)+2]), 4'(lv[4*(n%4)+1]), 4'(lv[4*(n%4)])})
			`CHK(err, 1'b0)
			line_n <= 8'(xs());
			per_req <= 8'(xs());
			setmask(4'(xs()));
			repeat (5) @(posedge clk_sys);
			#1 check({per_req, ~line_n}, int'(mask_in));
			@(posedge clk_sys);
		end
		line_n <= 8'hFF;
		per_req <= 8'h00;
		lv[0] = 9;
		lv[8] = 9;
		lv[2] = 6;
		wprio();
		setmask(4'h0);
		repeat (4) @(posedge clk_sys);
		for (int k = 2; k <= 3; k++) begin
			if (k == 2) per_req[0] <= 1'b1;
			else line_n[0] <= 1'b0;
			repeat (k - 1) @(posedge clk_sys);
			#1 `CHK(irq_req, 1'b0)
			@(posedge clk_sys);
			#1 `CHK(irq_req, 1'b1)
			@(posedge clk_sys);
			per_req <= 8'h00;
			line_n <= 8'hFF;
			repeat (4) @(posedge clk_sys);
		end
		apb(1'b1, OFS_SENSE, 32'h00000004);
		ack_en <= 1'b1;
		repeat (2) begin
			line_n[2] <= 1'b0;
			@(posedge clk_sys);
			line_n[2] <= 1'b1;
			@(posedge clk_sys);
		end
		repeat (24) @(posedge clk_sys);
		#1 `CHK(acc_ind_n, 1'b1)
		`CHK(acks, 1)
		@(posedge clk_sys);
		setmask(4'h0);
		repeat (24) @(posedge clk_sys);
		#1 `CHK(acks, 1)
		@(posedge clk_sys);
		ack_en <= 1'b0;
		apb(1'b1, OFS_PINFN, 32'h00000000);
		line_n[2] <= 1'b0;
		repeat (4) @(posedge clk_sys);
		#1 `CHK(irq_req, 1'b0)
		@(posedge clk_sys);
		apb(1'b1, OFS_PINFN, 32'h000000FF);
		repeat (4) @(posedge clk_sys);
		#1 `CHK(irq_src, 4'h2)
		`CHK(irq_req, 1'b1)
		`CHK(acc_ind_n, 1'b0)
		// ****************************************
		// Reset in mid-run with a request standing
		// ****************************************
		@(posedge clk_sys);
		rstn <= 1'b0;
		repeat (2) @(posedge clk_sys);
		rstn <= 1'b1;
		repeat (2) begin
			@(posedge clk_sys);
			#1 `CHK(irq_req, 1'b0)
			`CHK(acc_ind_n, 1'b1)
		end
		final_report();
	end
endmodule
